// [rtcee_bus_master.sv]
`timescale 1ns/1ps
// ********************************
// two-wire bus master model
// ********************************
module rtcee_bus_master (
    // clock
    input  wire logic ref_clk_i,
    // bus wires
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // one quarter period; data moves a quarter after scl falls
    task automatic s(input logic oe, input logic sc, output logic r);
        repeat (5) @(posedge ref_clk_i);
        r = sda_i;
        sda_oe_o <= oe;
        scl_o <= sc;
    endtask
    task automatic xbit(input logic tx, output logic rx);
        logic r;
        s(~tx, 1'b0, r);
        s(~tx, 1'b1, r);
        s(~tx, 1'b1, r);
        s(~tx, 1'b0, rx);
    endtask
    task automatic start();
        logic r;
        s(1'b0, 1'b0, r);
        s(1'b0, 1'b1, r);
        s(1'b1, 1'b1, r);
        s(1'b1, 1'b0, r);
    endtask
    task automatic stop();
        logic r;
        s(1'b1, 1'b0, r);
        s(1'b1, 1'b1, r);
        s(1'b0, 1'b1, r);
        s(1'b0, 1'b1, r);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xbit(d[i], r);
        xbit(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            xbit(1'b1, d[i]);
        xbit(~ack, r);
    endtask
endmodule

// [rtcee_defines.vh]
`ifndef RTCEE_DEFINES_VH
`define RTCEE_DEFINES_VH

// ****************************************
// slave address byte layout
// ****************************************
`define RTCEE_ID_HI        7
`define RTCEE_ID_LO        4
`define RTCEE_SEL_HI       3
`define RTCEE_SEL_LO       1
`define RTCEE_RW_BIT       0
`define RTCEE_ID_ARRAY     4'ha
`define RTCEE_ID_CTL       4'hd
`define RTCEE_SEL_VALUE    3'h7

// ****************************************
// address space
// ****************************************
`define RTCEE_ADDR_RST     16'h0000
`define RTCEE_ARR_AW       9
`define RTCEE_ARR_DEPTH    512
`define RTCEE_CTL_AW       6
`define RTCEE_CTL_DEPTH    64
`define RTCEE_PAGE_BYTES   16
`define RTCEE_WKDAY_OFS    3'h6

// ****************************************
// bit counting and timing
// ****************************************
`define RTCEE_BYTE_BITS    4'h8
`define RTCEE_CLK_NS       4
`define RTCEE_T_WR_NS      12000000
`define RTCEE_WR_CYCLES    (`RTCEE_T_WR_NS / `RTCEE_CLK_NS)
`define RTCEE_BUSY_W       22

`endif

// [rtcee_nv_store.v]
`timescale 1ns/1ps
`include "rtcee_defines.vh"

module rtcee_nv_store (
    // clock
    input  wire       ref_clk_i,
    // commit port
    input  wire       we_i,
    input  wire       wsel_ctl_i,
    input  wire [8:0] waddr_i,
    input  wire [7:0] wdata_i,
    // read port
    input  wire       rsel_ctl_i,
    input  wire [8:0] raddr_i,
    output wire [7:0] rdata_o
);

    // contents start undefined, like a fresh part
    reg [7:0] arr_mem [0:`RTCEE_ARR_DEPTH-1];
    reg [7:0] ctl_mem [0:`RTCEE_CTL_DEPTH-1];

    always @(posedge ref_clk_i)
    begin
        if (we_i && !wsel_ctl_i)
            arr_mem[waddr_i] <= wdata_i;
        if (we_i && wsel_ctl_i)
            ctl_mem[waddr_i[`RTCEE_CTL_AW-1:0]] <= wdata_i;
    end

    assign rdata_o = rsel_ctl_i ? ctl_mem[raddr_i[`RTCEE_CTL_AW-1:0]]
                                : arr_mem[raddr_i];

endmodule

// [rtcee_pin_sync.v]
`timescale 1ns/1ps
`include "rtcee_defines.vh"

module rtcee_pin_sync (
    // clock and reset
    input  wire ref_clk_i,
    input  wire reset_i,
    // raw bus pins
    input  wire scl_i,
    input  wire sda_i,
    // synchronised levels and events
    output wire scl_s_o,
    output wire sda_s_o,
    output wire scl_rise_o,
    output wire scl_fall_o,
    output wire start_o,
    output wire stop_o
);

    reg  [1:0] meta_q;
    reg  [1:0] sync_q;
    reg  [1:0] dly_q;
    wire [1:0] pins = {sda_i, scl_i};

    // ****************************************
    // two-stage synchronisers, one per pin
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_pin
            always @(posedge ref_clk_i)
            begin
                if (reset_i)
                begin
                    meta_q[g] <= 1'b1;
                    sync_q[g] <= 1'b1;
                    dly_q[g]  <= 1'b1;
                end
                else
                begin
                    meta_q[g] <= pins[g];
                    sync_q[g] <= meta_q[g];
                    dly_q[g]  <= sync_q[g];
                end
            end
        end
    endgenerate

    // edges use the second and third stages only
    assign scl_s_o    = sync_q[0];
    assign sda_s_o    = sync_q[1];
    assign scl_rise_o = sync_q[0] & ~dly_q[0];
    assign scl_fall_o = ~sync_q[0] & dly_q[0];
    assign start_o    = sync_q[0] & dly_q[0] & ~sync_q[1] & dly_q[1];
    assign stop_o     = sync_q[0] & dly_q[0] & sync_q[1] & ~dly_q[1];

endmodule

// [rtcee_serial_slave.v]
`timescale 1ns/1ps
`include "rtcee_defines.vh"

// Operation
// R1 - id nibble 1010 picks the array, 1101 the clock/control space
// R2 - select bits three to one must read 111
// R3 - address bit zero: one reads, zero writes
// R4 - compare whole address byte; acknowledge on match, stay silent otherwise
// R5 - write address byte is followed by a two-byte word address
// R6 - reset clears the sixteen-bit address counter to zero
// R7 - random read reuses the same address byte in both phases
// R8 - master unlocks control space writes with 02h then 06h
// R9 - acknowledge address and data bytes; stop starts a write cycle
// R10 - protected writes are acknowledged but neither stored nor committed
// R11 - a single byte to a weekday alarm register is not committed
// R12 - page holds sixteen array bytes or eight control bytes
// R13 - master writes clock registers as a full eight-byte page
// R14 - write address increments and wraps inside its page
// R15 - surplus page bytes overwrite earlier ones at the wrapped slot
// R16 - stop before a full data byte or mid-byte aborts the write
// R17 - array address not acknowledged while the write cycle runs
// R18 - master polls with the array address byte only
// R19 - current read sends the byte at the counter, then increments
// R20 - master ends a read with stop or no-acknowledge then stop
// R21 - stop after word address loads counter and goes to standby
// R22 - sequential read continues on acknowledge, wraps at space end
// R23 - no acknowledge after a read byte ends sending until stop
// R24 - stop after a read returns to standby
// R25 - array uses nine address bits; reads wrap at 512

module rtcee_serial_slave #(
    parameter WR_CYCLES = `RTCEE_WR_CYCLES
) (
    // clock and reset
    input  wire ref_clk_i,
    input  wire reset_i,
    // two-wire bus pins
    input  wire scl_i,
    input  wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    // protection and status
    input  wire array_protect_i,
    output wire write_busy_o
);

    // ****************************************
    // states and constants
    // ****************************************
    localparam ST_IDLE   = 3'd0;
    localparam ST_DEV    = 3'd1;
    localparam ST_AHI    = 3'd2;
    localparam ST_ALO    = 3'd3;
    localparam ST_WDATA  = 3'd4;
    localparam ST_RDATA  = 3'd5;
    localparam ST_IGNORE = 3'd6;

    localparam integer BW      = `RTCEE_BUSY_W;
    localparam integer BL_INT  = WR_CYCLES - 1;
    localparam [BW-1:0] BUSY_LAST = BL_INT[BW-1:0];

    // ****************************************
    // decoding helpers
    // ****************************************
    function [8:0] page_addr;
        input        sel_ctl;
        input [15:0] base;
        input [3:0]  idx;
        begin
            if (sel_ctl)
                page_addr = {3'h0, base[5:3], idx[2:0]};
            else
                page_addr = {base[8:4], idx};
        end
    endfunction

    function [15:0] wr_next;
        input        sel_ctl;
        input [15:0] a;
        begin
            if (sel_ctl)
                wr_next = {a[15:3], a[2:0] + 3'h1};
            else
                wr_next = {a[15:4], a[3:0] + 4'h1};
        end
    endfunction

    function [15:0] rd_next;
        input        sel_ctl;
        input [15:0] a;
        begin
            if (sel_ctl)
                rd_next = {10'h000, a[5:0] + 6'h01};
            else
                rd_next = {7'h00, a[8:0] + 9'h001};
        end
    endfunction

    // ****************************************
    // pin synchronisation
    // ****************************************
    // only the clock's edges matter here, not its level
    wire       sda_s;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;

    rtcee_pin_sync u_sync (
        .ref_clk_i  (ref_clk_i),
        .reset_i    (reset_i),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .scl_s_o    (),
        .sda_s_o    (sda_s),
        .scl_rise_o (scl_rise),
        .scl_fall_o (scl_fall),
        .start_o    (start_det),
        .stop_o     (stop_det)
    );

    // ****************************************
    // state
    // ****************************************
    reg [2:0]    state_q;
    reg [3:0]    bit_q;
    reg          ackph_q;
    reg [7:0]    shift_q;
    reg [7:0]    tx_q;
    reg          nack_q;
    reg          ctl_q;
    reg [7:0]    ahi_q;
    reg [15:0]   addr_q;
    reg [1:0]    wcnt_q;
    reg [2:0]    wfirst_q;
    reg          wprot_q;
    reg [15:0]   pval_q;
    reg          cmt_q;
    reg [3:0]    cidx_q;
    reg          busy_q;
    reg [BW-1:0] bcnt_q;
    reg          sda_oe_q;
    reg          sda_lo_q;
    reg [7:0]    pbuf [0:`RTCEE_PAGE_BYTES-1];

    wire [7:0] rd_data;
    wire [3:0] wr_idx = ctl_q ? {1'b0, addr_q[2:0]} : addr_q[3:0];
    wire       byte_done = scl_fall & ~ackph_q & (bit_q == `RTCEE_BYTE_BITS)
                           & ~busy_q & ~start_det & ~stop_det;
    wire       pb_we = byte_done & (state_q == ST_WDATA) & ~wprot_q;
    wire [3:0] id_nib = shift_q[`RTCEE_ID_HI:`RTCEE_ID_LO];
    wire       id_arr = id_nib == `RTCEE_ID_ARRAY;
    wire       id_ctl = id_nib == `RTCEE_ID_CTL;
    wire       sel_ok = shift_q[`RTCEE_SEL_HI:`RTCEE_SEL_LO]
                        == `RTCEE_SEL_VALUE;
    // a lone weekday byte would never reach nonvolatile storage
    wire       wk_only = ctl_q & (wcnt_q == 2'd1)
                         & (wfirst_q == `RTCEE_WKDAY_OFS);
    wire       commit_ok = (state_q == ST_WDATA) & ~ackph_q
                           & (bit_q <= 4'h1) & (wcnt_q != 2'd0)
                           & ~wprot_q & ~wk_only;

    rtcee_nv_store u_store (
        .ref_clk_i  (ref_clk_i),
        .we_i       (cmt_q & pval_q[cidx_q]),
        .wsel_ctl_i (ctl_q),
        .waddr_i    (page_addr(ctl_q, addr_q, cidx_q)),
        .wdata_i    (pbuf[cidx_q]),
        .rsel_ctl_i (ctl_q),
        .raddr_i    (page_addr(ctl_q, addr_q, addr_q[3:0])),
        .rdata_o    (rd_data)
    );

    // ****************************************
    // page buffer
    // ****************************************
    // later bytes simply land on the wrapped slot again
    always @(posedge ref_clk_i)
    begin
        if (pb_we)
            pbuf[wr_idx] <= shift_q; // R15
    end

    // ****************************************
    // bus engine and write cycle
    // ****************************************
    always @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state_q  <= ST_IDLE;
            bit_q    <= 4'h0;
            ackph_q  <= 1'b0;
            shift_q  <= 8'h00;
            tx_q     <= 8'h00;
            nack_q   <= 1'b1;
            ctl_q    <= 1'b0;
            ahi_q    <= 8'h00;
            addr_q   <= `RTCEE_ADDR_RST; // R6
            wcnt_q   <= 2'd0;
            wfirst_q <= 3'h0;
            wprot_q  <= 1'b0;
            pval_q   <= 16'h0000;
            cmt_q    <= 1'b0;
            cidx_q   <= 4'h0;
            busy_q   <= 1'b0;
            bcnt_q   <= {BW{1'b0}};
            sda_oe_q <= 1'b0;
            sda_lo_q <= 1'b0;
        end
        else if (busy_q)
        begin
            // inputs deaf and line released for the whole cycle
            state_q  <= ST_IDLE; // R9 R17
            sda_oe_q <= 1'b0; // R9
            ackph_q  <= 1'b0;
            bit_q    <= 4'h0;
            if (cmt_q)
            begin
                cidx_q <= cidx_q + 4'h1;
                if (cidx_q == 4'hf)
                    cmt_q <= 1'b0;
            end
            else if (bcnt_q == BUSY_LAST)
            begin
                busy_q <= 1'b0;
                bcnt_q <= {BW{1'b0}};
            end
            else
                bcnt_q <= bcnt_q + 1'b1;
        end
        else if (start_det)
        begin
            state_q  <= ST_DEV;
            bit_q    <= 4'h0;
            ackph_q  <= 1'b0;
            sda_oe_q <= 1'b0;
            pval_q   <= 16'h0000;
            wcnt_q   <= 2'd0;
            wprot_q  <= 1'b0;
        end
        else if (stop_det)
        begin
            state_q  <= ST_IDLE; // R21 R24
            bit_q    <= 4'h0;
            ackph_q  <= 1'b0;
            sda_oe_q <= 1'b0;
            if (commit_ok) // R9 R10 R11 R16
            begin
                busy_q <= 1'b1;
                cmt_q  <= 1'b1;
                cidx_q <= 4'h0;
            end
        end
        else
        begin
            case (state_q)
                ST_DEV, ST_AHI, ST_ALO, ST_WDATA, ST_RDATA:
                begin
                    if (scl_rise)
                    begin
                        if (ackph_q)
                            nack_q <= sda_s;
                        else
                        begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_q   <= bit_q + 4'h1;
                        end
                    end
                    else if (scl_fall && ackph_q)
                    begin
                        ackph_q  <= 1'b0;
                        bit_q    <= 4'h0;
                        sda_oe_q <= 1'b0;
                        if (state_q == ST_RDATA)
                        begin
                            // own ack reads as low, so first byte loads
                            if (nack_q)
                                state_q <= ST_IGNORE; // R23
                            else
                            begin
                                tx_q     <= {rd_data[6:0], 1'b0}; // R19
                                sda_oe_q <= ~rd_data[7];
                                addr_q   <= rd_next(ctl_q, addr_q); // R22 R25
                            end
                        end
                    end
                    else if (byte_done)
                    begin
                        ackph_q  <= 1'b1;
                        sda_oe_q <= 1'b1; // R9
                        case (state_q)
                            ST_DEV:
                            begin
                                if ((id_arr || id_ctl) && sel_ok) // R1 R2 R4
                                begin
                                    ctl_q   <= id_ctl; // R1
                                    state_q <= shift_q[`RTCEE_RW_BIT]
                                               ? ST_RDATA : ST_AHI; // R3
                                end
                                else
                                begin
                                    ackph_q  <= 1'b0;
                                    sda_oe_q <= 1'b0; // R4
                                    state_q  <= ST_IGNORE;
                                end
                            end
                            ST_AHI:
                            begin
                                ahi_q   <= shift_q; // R5
                                state_q <= ST_ALO;
                            end
                            ST_ALO:
                            begin
                                addr_q  <= {ahi_q, shift_q}; // R5 R21
                                wprot_q <= ~ctl_q & array_protect_i; // R10
                                state_q <= ST_WDATA;
                            end
                            ST_WDATA:
                            begin
                                if (!wprot_q)
                                begin
                                    pval_q[wr_idx] <= 1'b1; // R12
                                    addr_q <= wr_next(ctl_q, addr_q); // R14
                                end
                                if (wcnt_q == 2'd0)
                                    wfirst_q <= addr_q[2:0];
                                if (wcnt_q != 2'd2)
                                    wcnt_q <= wcnt_q + 2'd1;
                            end
                            ST_RDATA:
                                sda_oe_q <= 1'b0;
                            default:
                                sda_oe_q <= 1'b0;
                        endcase
                    end
                    else if (scl_fall && state_q == ST_RDATA)
                    begin
                        sda_oe_q <= ~tx_q[7];
                        tx_q     <= {tx_q[6:0], 1'b0};
                    end
                end
                default:
                    sda_oe_q <= 1'b0;
            endcase
        end
    end

    assign sda_o        = sda_lo_q;
    assign sda_oe_o     = sda_oe_q;
    assign write_busy_o = busy_q;

endmodule

// [rtcee_serial_slave_chk.sv]
`timescale 1ns/1ps
// ********************************
// serial slave port checker
// ********************************
module rtcee_serial_slave_chk #(
    parameter WR_CYCLES = 50
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // protection and status
    input wire logic array_protect_i,
    input wire logic write_busy_o
);
    int   busy_cnt_q;
    int   stop_age_q;
    logic scl_p_q;
    logic sda_p_q;

    // stop seen on the raw pins, ahead of the design's synchroniser
    always @(posedge ref_clk_i)
    begin
        scl_p_q <= scl_i;
        sda_p_q <= sda_i;
        if (reset_i || !write_busy_o)
            busy_cnt_q <= 0;
        else
            busy_cnt_q <= busy_cnt_q + 1;
        if (reset_i)
            stop_age_q <= 1000;
        else if (scl_i && scl_p_q && sda_i && !sda_p_q)
            stop_age_q <= 0;
        else if (stop_age_q < 1000)
            stop_age_q <= stop_age_q + 1;
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence scl_pulse_s;
        ##[1:40] $rose(scl_i) ##[1:40] $fell(scl_i);
    endsequence

    drive_low_a: assert property (sda_o == 1'b0)
        else $error("data drive value not low");
    busy_quiet_a: assert property (write_busy_o |-> !sda_oe_o)
        else $error("data line driven during write cycle");
    busy_len_a: assert property (
        $fell(write_busy_o) |-> busy_cnt_q == WR_CYCLES + 16)
        else $error("write cycle length wrong");
    busy_cap_a: assert property (
        write_busy_o |-> busy_cnt_q < WR_CYCLES + 16)
        else $error("write cycle too long");
    busy_cause_a: assert property (
        $rose(write_busy_o) |-> stop_age_q < 8)
        else $error("write cycle without stop");
    oe_lag_a: assert property (
        $changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
        else $error("data drive changed outside clock low");
    ack_hold_a: assert property (
        $rose(sda_oe_o) |-> sda_oe_o throughout scl_pulse_s)
        else $error("driven bit not held over clock pulse");
    reset_clear_a: assert property (
        @(posedge ref_clk_i) disable iff (1'b0)
        reset_i |=> !sda_oe_o && !write_busy_o)
        else $error("outputs not cleared by reset");
endmodule

bind rtcee_serial_slave rtcee_serial_slave_chk #(
    .WR_CYCLES(WR_CYCLES)
) chk_u (
    .ref_clk_i       (ref_clk_i),
    .reset_i         (reset_i),
    .scl_i           (scl_i),
    .sda_i           (sda_i),
    .sda_o           (sda_o),
    .sda_oe_o        (sda_oe_o),
    .array_protect_i (array_protect_i),
    .write_busy_o    (write_busy_o)
);

// [tb_top.sv]
`timescale 1ns/1ps
// ********************************
// serial slave testbench
// ********************************
module tb_top;
    localparam int WRC = 400;
    // status register slot, value arbitrary
    localparam logic [15:0] STAT_A = 16'h003f;
    logic       clk;
    logic       rst;
    logic       prot;
    wire        scl;
    wire        m_oe;
    wire        d_o;
    wire        d_oe;
    wire        busy;
    wire        sda;
    logic [7:0] mem [0:575];
    int         n_mismatch = 0;
    int         n_checks = 0;
    // pull-up: a released wire reads high
    assign sda = !(m_oe || (d_oe && !d_o));

    rtcee_serial_slave #(
        .WR_CYCLES(WRC)
    ) dut_u (
        .ref_clk_i       (clk),
        .reset_i         (rst),
        .scl_i           (scl),
        .sda_i           (sda),
        .sda_o           (d_o),
        .sda_oe_o        (d_oe),
        .array_protect_i (prot),
        .write_busy_o    (busy)
    );
    rtcee_bus_master mst_u (
        .ref_clk_i (clk),
        .sda_i     (sda),
        .scl_o     (scl),
        .sda_oe_o  (m_oe)
    );

    task automatic print_verdict();
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic ck(input logic seen, input logic exp);
        chk({7'h00, seen}, {7'h00, exp});
    endtask
    function automatic int key(input logic c, input logic [15:0] a);
        return c ? 512 + int'(a[5:0]) : int'(a[8:0]);
    endfunction
    task automatic hdr(input logic [7:0] sa, input logic [15:0] a);
        logic k;
        mst_u.start();
        mst_u.wr_byte(sa, k);
        ck(k, 1'b1);
        mst_u.wr_byte(a[15:8], k);
        ck(k, 1'b1);
        mst_u.wr_byte(a[7:0], k);
        ck(k, 1'b1);
    endtask
    task automatic wait_busy(input logic exp);
        logic k;
        logic sb;
        sb = 1'b0;
        repeat (12)
        begin
            @(posedge clk);
            sb = sb | busy;
        end
        ck(sb, exp);
        if (exp)
        begin
            mst_u.start();
            mst_u.wr_byte(8'hae, k);
            ck(k, 1'b0);
            mst_u.stop();
            repeat (WRC + 40)
                if (busy)
                    @(posedge clk);
            ck(busy, 1'b0);
            mst_u.start();
            mst_u.wr_byte(8'hae, k);
            ck(k, 1'b1);
            mst_u.stop();
        end
    endtask
    task automatic wr_pg(input logic [7:0] sa, input logic [15:0] a,
                         input int n, input logic [7:0] d0, input logic cm);
        logic        k;
        logic [15:0] m;
        logic [15:0] p;
        m = sa[4] ? 16'h0007 : 16'h000f;
        hdr(sa, a);
        for (int i = 0; i < n; i++)
        begin
            mst_u.wr_byte(d0 + 8'(i), k);
            ck(k, 1'b1);
            p = (a & ~m) | ((a + 16'(i)) & m);
            if (cm)
                mem[key(sa[4], p)] = d0 + 8'(i);
        end
        mst_u.stop();
        wait_busy(cm);
    endtask
    task automatic rd(input logic [7:0] sa, input logic [15:0] a, input int n);
        logic       k;
        logic [7:0] d;
        mst_u.start();
        mst_u.wr_byte(sa | 8'h01, k);
        ck(k, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            mst_u.rd_byte(i < n - 1, d);
            chk(d, mem[key(sa[4], a + 16'(i))]);
        end
        mst_u.rd_byte(1'b0, d);
        chk(d, 8'hff);
        mst_u.stop();
    endtask

    task automatic t_addr();
        logic [7:0] sa [8] = '{8'hae, 8'haf, 8'hde, 8'hdf,
                               8'ha2, 8'hee, 8'h5e, 8'hd6};
        logic       k;
        logic [7:0] d;
        for (int i = 0; i < 8; i++)
        begin
            mst_u.start();
            mst_u.wr_byte(sa[i], k);
            ck(k, i < 4);
            if (k && sa[i][0])
                mst_u.rd_byte(1'b0, d);
            mst_u.stop();
        end
    endtask
    task automatic t_page();
        wr_pg(8'hae, 16'h01fa, 20, 8'h40, 1'b1);
        rd(8'hae, 16'h01fe, 1);
        wr_pg(8'hae, 16'h0000, 16, 8'h80, 1'b1);
        hdr(8'hae, 16'h01f8);
        rd(8'hae, 16'h01f8, 16);
        rd(8'hae, 16'h0008, 1);
    endtask
    task automatic t_ctl();
        wr_pg(8'hde, STAT_A, 1, 8'h02, 1'b1);
        wr_pg(8'hde, STAT_A, 1, 8'h06, 1'b1);
        wr_pg(8'hde, 16'h0013, 8, 8'hc0, 1'b1);
        hdr(8'hde, 16'h0010);
        rd(8'hde, 16'h0010, 8);
        wr_pg(8'hde, 16'h0016, 1, 8'h5a, 1'b0);
        hdr(8'hde, 16'h0016);
        rd(8'hde, 16'h0016, 1);
    endtask
    task automatic t_abort();
        logic r;
        hdr(8'hae, 16'h0005);
        for (int i = 0; i < 4; i++)
            mst_u.xbit(1'b0, r);
        mst_u.stop();
        wait_busy(1'b0);
        rd(8'hae, 16'h0005, 1);
        hdr(8'hae, 16'h0009);
        mst_u.stop();
        wait_busy(1'b0);
        rd(8'hae, 16'h0009, 1);
    endtask
    task automatic t_prot();
        prot <= 1'b1;
        wr_pg(8'hae, 16'h0003, 1, 8'h11, 1'b0);
        prot <= 1'b0;
        hdr(8'hae, 16'h0003);
        rd(8'hae, 16'h0003, 1);
    endtask
    task automatic t_reset();
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        rd(8'hae, 16'h0000, 1);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        rst = 1'b1;
        prot = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_addr();
        t_page();
        t_ctl();
        t_abort();
        t_prot();
        t_reset();
        print_verdict();
    end
    // the whole sequence needs about thirty-one thousand clocks
    initial
    begin
        repeat (95000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
